// ===== rtl/suvm_pkg.sv
// package: register map, field layout and state codes of the supply lockout monitor
package suvm_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] SUVM_ADDR_IRQ_STATUS_TWO = 8'h1A;
  localparam logic [7:0] SUVM_ADDR_IRQ_STATUS_TWO_MASK = 8'h22;
  localparam logic [7:0] SUVM_ADDR_SUPPLY_CHECK_COMPARATOR = 8'hB3;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int SUVM_BIT_HYST_FAIL = 3;
  localparam int SUVM_BIT_ACTION = 14;
  localparam int SUVM_OFF_THR_LSB = 4;
  localparam int SUVM_ON_THR_LSB = 0;
  localparam logic [2:0] SUVM_OFF_THR_RST = 3'h2;
  localparam logic [2:0] SUVM_ON_THR_RST = 3'h5;
  localparam logic SUVM_ACTION_RST = 1'h0;

  // ****************************************
  // power states
  // ****************************************
  typedef enum logic [1:0] {
    SUVM_ST_BACKUP = 2'b00,
    SUVM_ST_OFF = 2'b01,
    SUVM_ST_ACTIVE = 2'b10,
    SUVM_ST_HIBERNATE = 2'b11
  } suvm_state_e;

endpackage : suvm_pkg

// ===== rtl/suvm_monitor.sv
// module: supply undervoltage lockout monitor with power state machine and hysteresis irq
// Overview of operation
// RULE1: supplies below lockout force backup state
// RULE2: backup to off only above lockout
// RULE3: active, hibernate, off fall to backup
// RULE4: off to active only above startup
// RULE5: below shutdown threshold sets failure flag
// RULE6: bit 14 selects irq only or shutdown
// RULE7: shutdown threshold bits 6:4, reset 010
// RULE8: startup threshold bits 2:0, reset 101
// RULE9: thresholds writable only when key unlocked
// RULE10: flag set on rising edge, read clears
// RULE11: mask bit 3 blocks system interrupt
// RULE12: unmasked flag drives system interrupt
// RULE13: software keeps startup above shutdown
// RULE14: comparator outputs synchronised before use
`timescale 1ns/1ps
`default_nettype none

module suvm_monitor
  import suvm_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // analog comparators, asynchronous, high while supply is above the level
  input wire logic i_line_above_lockout,
  input wire logic i_line_above_startup,
  input wire logic i_line_above_shutdown,
  // power requests from the sequencer
  input wire logic i_req_start,
  input wire logic i_req_hibernate,
  input wire logic i_req_wake,
  input wire logic i_req_off,
  // security key state
  input wire logic i_key_unlocked,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  // threshold codes to the comparators and status
  output logic [2:0] o_shutdown_threshold,
  output logic [2:0] o_startup_threshold,
  output logic [1:0] o_power_state,
  output logic o_system_irq
);

  // ****************************************
  // comparator synchronisers
  // ****************************************
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] nxt_sync1;
  logic [2:0] nxt_sync2;
  logic [1:0] valid_ff;
  logic [1:0] nxt_valid;
  logic sync_valid;
  logic lockout_ok;
  logic startup_ok;
  logic shutdown_ok;

  always_comb begin
    nxt_sync1 = {i_line_above_shutdown, i_line_above_startup, i_line_above_lockout};
    nxt_sync2 = sync1_ff;
    nxt_valid = {valid_ff[0], 1'h1};
  end

  // reset value treats every supply as low until sampled
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      valid_ff <= 2'h0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2; // RULE14
      valid_ff <= nxt_valid;
    end
  end

  assign lockout_ok = sync2_ff[0];
  assign startup_ok = sync2_ff[1];
  assign shutdown_ok = sync2_ff[2];
  assign sync_valid = valid_ff[1];

  // ****************************************
  // registers and interrupt flag
  // ****************************************
  logic action_ff;
  logic [2:0] off_thr_ff;
  logic [2:0] on_thr_ff;
  logic flag_ff;
  logic mask_ff;
  logic below_prev_ff;
  logic nxt_action;
  logic [2:0] nxt_off_thr;
  logic [2:0] nxt_on_thr;
  logic nxt_flag;
  logic nxt_mask;
  logic nxt_below_prev;
  logic below_shutdown;
  logic fail_rise;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  always_comb begin
    // the synchroniser reset value reads as below; without this gate
    // every reset would raise a false failure edge
    below_shutdown = sync_valid && !shutdown_ok;
    fail_rise = below_shutdown && !below_prev_ff;
    nxt_below_prev = below_shutdown;
    nxt_action = action_ff;
    nxt_off_thr = off_thr_ff;
    nxt_on_thr = on_thr_ff;
    nxt_mask = mask_ff;
    nxt_flag = flag_ff;
    if (i_reg_wr && hit(i_reg_addr, SUVM_ADDR_SUPPLY_CHECK_COMPARATOR)) begin
      nxt_action = i_reg_wdata[SUVM_BIT_ACTION]; // RULE6
      if (i_key_unlocked) begin // RULE9
        nxt_off_thr = i_reg_wdata[SUVM_OFF_THR_LSB +: 3]; // RULE7
        nxt_on_thr = i_reg_wdata[SUVM_ON_THR_LSB +: 3]; // RULE8
      end
    end
    if (i_reg_wr && hit(i_reg_addr, SUVM_ADDR_IRQ_STATUS_TWO_MASK)) begin
      nxt_mask = i_reg_wdata[SUVM_BIT_HYST_FAIL];
    end
    // read clears, but a new edge in the same cycle wins
    if (i_reg_rd && hit(i_reg_addr, SUVM_ADDR_IRQ_STATUS_TWO)) begin
      nxt_flag = 1'b0; // RULE10
    end
    if (fail_rise) begin
      nxt_flag = 1'b1; // RULE5 RULE10
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      action_ff <= SUVM_ACTION_RST;
      off_thr_ff <= SUVM_OFF_THR_RST;
      on_thr_ff <= SUVM_ON_THR_RST;
      mask_ff <= 1'b0;
      flag_ff <= 1'b0;
      below_prev_ff <= 1'b0;
    end else begin
      action_ff <= nxt_action;
      off_thr_ff <= nxt_off_thr;
      on_thr_ff <= nxt_on_thr;
      mask_ff <= nxt_mask;
      flag_ff <= nxt_flag;
      below_prev_ff <= nxt_below_prev;
    end
  end

  assign o_shutdown_threshold = off_thr_ff;
  assign o_startup_threshold = on_thr_ff;
  assign o_system_irq = flag_ff && !mask_ff; // RULE11 RULE12

  // read data is registered so the port comes from flip-flops
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 16'h0000;
    if (i_reg_rd) begin
      if (hit(i_reg_addr, SUVM_ADDR_IRQ_STATUS_TWO)) begin
        nxt_rdata[SUVM_BIT_HYST_FAIL] = flag_ff;
      end else if (hit(i_reg_addr, SUVM_ADDR_IRQ_STATUS_TWO_MASK)) begin
        nxt_rdata[SUVM_BIT_HYST_FAIL] = mask_ff;
      end else if (hit(i_reg_addr, SUVM_ADDR_SUPPLY_CHECK_COMPARATOR)) begin
        nxt_rdata[SUVM_BIT_ACTION] = action_ff;
        nxt_rdata[SUVM_OFF_THR_LSB +: 3] = off_thr_ff;
        nxt_rdata[SUVM_ON_THR_LSB +: 3] = on_thr_ff;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_reg_rdata = rdata_ff;

  // ****************************************
  // power state machine
  // ****************************************
  suvm_state_e state_ff;
  suvm_state_e nxt_state;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SUVM_ST_BACKUP: begin
        if (lockout_ok) begin
          nxt_state = SUVM_ST_OFF; // RULE2
        end
      end
      SUVM_ST_OFF: begin
        if (i_req_start && startup_ok) begin
          nxt_state = SUVM_ST_ACTIVE; // RULE4
        end
      end
      SUVM_ST_ACTIVE: begin
        if (i_req_off || (fail_rise && action_ff)) begin
          nxt_state = SUVM_ST_OFF; // RULE6
        end else if (i_req_hibernate) begin
          nxt_state = SUVM_ST_HIBERNATE;
        end
      end
      SUVM_ST_HIBERNATE: begin
        if (i_req_off || (fail_rise && action_ff)) begin
          nxt_state = SUVM_ST_OFF; // RULE6
        end else if (i_req_wake) begin
          nxt_state = SUVM_ST_ACTIVE;
        end
      end
    endcase
    // lockout overrides every other transition
    if (!lockout_ok) begin
      nxt_state = SUVM_ST_BACKUP; // RULE1 RULE3
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_ff <= SUVM_ST_BACKUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_power_state = state_ff;

endmodule : suvm_monitor

`default_nettype wire

// ===== testbench/suvm_monitor_checker.sv
// checker: port-level assertions for the supply lockout monitor
`timescale 1ns/1ps
`default_nettype none
module suvm_monitor_checker
  import suvm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_line_above_lockout,
  input wire logic i_line_above_startup,
  input wire logic i_line_above_shutdown,
  input wire logic i_key_unlocked,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic [2:0] o_shutdown_threshold,
  input wire logic [2:0] o_startup_threshold,
  input wire logic [1:0] o_power_state,
  input wire logic o_system_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic thr_wr;
  assign thr_wr = i_reg_wr && i_key_unlocked && i_reg_addr == SUVM_ADDR_SUPPLY_CHECK_COMPARATOR;
  sequence s_move(a, b);
    o_power_state == a ##1 o_power_state == b;
  endsequence
  AST_LOCK_BACKUP: assert property (
    !i_line_above_lockout [*4] |-> o_power_state == SUVM_ST_BACKUP) else $error("not backup");
  AST_BACKUP_EXIT: assert property (
    o_power_state == SUVM_ST_BACKUP ##1 o_power_state != SUVM_ST_BACKUP
    |-> o_power_state == SUVM_ST_OFF && $past(i_line_above_lockout, 3)) else $error("exit");
  AST_START_GATE: assert property (
    s_move(SUVM_ST_OFF, SUVM_ST_ACTIVE) |-> $past(i_line_above_startup, 3)) else $error("start");
  AST_IRQ_RISE: assert property (
    $rose(o_system_irq) |-> $past(!i_line_above_shutdown, 3) || $past(i_reg_wr))
    else $error("irq rise");
  AST_IRQ_FALL: assert property (
    $fell(o_system_irq) |-> $past(i_reg_rd || i_reg_wr)) else $error("irq fall");
  AST_RDATA_IDLE: assert property (
    !$past(i_reg_rd) |-> o_reg_rdata == 16'h0000) else $error("rdata");
  AST_THR_LOCKED: assert property (
    $changed({o_shutdown_threshold, o_startup_threshold}) |-> $past(thr_wr)) else $error("thr");
  AST_THR_WRITE: assert property (
    thr_wr |=> {o_shutdown_threshold, o_startup_threshold} == $past({i_reg_wdata[6:4],
    i_reg_wdata[2:0]})) else $error("thr write");
endmodule : suvm_monitor_checker
bind suvm_monitor suvm_monitor_checker chk (.*);
`default_nettype wire

// ===== testbench/suvm_supply_model.sv
// partner: supply comparators fed by a line voltage in 0.1 V steps
`timescale 1ns/1ps
`default_nettype none
module suvm_supply_model #(parameter int LOCK_DV = 25) (
  input wire logic [7:0] i_dv,
  input wire logic [2:0] i_off,
  input wire logic [2:0] i_on,
  output logic o_lock,
  output logic o_on,
  output logic o_off
);
  // code 000 sits at 2.9 V, one code per step
  assign o_lock = i_dv > LOCK_DV;
  assign o_on = i_dv > 8'h1D + i_on;
  assign o_off = i_dv > 8'h1D + i_off;
endmodule : suvm_supply_model
`default_nettype wire

// ===== testbench/supply_undervoltage_lockout_monitor_test.sv
// testbench: directed scenarios for the supply lockout monitor
`timescale 1ns/1ps
`default_nettype none
module supply_undervoltage_lockout_monitor_test;
  import suvm_pkg::*;
  logic i_clk_sys = 0, i_rst_n = 0, i_req_start = 0, i_key_unlocked = 0, o_system_irq;
  logic i_req_hibernate = 0, i_req_wake = 0, i_req_off = 0, i_reg_wr = 0, i_reg_rd = 0;
  logic i_line_above_lockout, i_line_above_startup, i_line_above_shutdown;
  logic [7:0] i_reg_addr = 8'h00, dv = 8'h00;
  logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
  logic [2:0] o_shutdown_threshold, o_startup_threshold;
  logic [1:0] o_power_state;
  int n_errors = 0, comparisons = 0, cycles = 0;
  suvm_monitor dut (.*);
  suvm_supply_model sup (.i_dv(dv), .i_off(o_shutdown_threshold), .i_on(o_startup_threshold),
    .o_lock(i_line_above_lockout), .o_on(i_line_above_startup), .o_off(i_line_above_shutdown));
  initial forever #2 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    @(negedge i_clk_sys) i_reg_wr = 0;
    @(negedge i_clk_sys);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [15:0] exp);
    i_reg_addr = a;
    i_reg_rd = 1;
    @(negedge i_clk_sys) i_reg_rd = 0;
    chk(o_reg_rdata, exp);
    @(negedge i_clk_sys);
  endtask : rreg
  // comparator changes take three edges, six leaves margin
  task automatic line(input logic [7:0] v);
    dv = v;
    repeat (6) @(negedge i_clk_sys);
  endtask : line
  task automatic go(input logic [7:0] v, input logic [1:0] st);
    line(v);
    i_req_start = 1;
    repeat (3) @(negedge i_clk_sys);
    i_req_start = 0;
    chk(16'(o_power_state), 16'(st));
  endtask : go
  // one-cycle request on {off, wake, hibernate}, then the state is judged
  task automatic req(input logic [2:0] r, input logic [1:0] st);
    {i_req_off, i_req_wake, i_req_hibernate} = r;
    @(negedge i_clk_sys);
    {i_req_off, i_req_wake, i_req_hibernate} = 3'h0;
    chk(16'(o_power_state), 16'(st));
    @(negedge i_clk_sys);
  endtask : req
  // reset in mid-run with the line above every level: no false failure edge
  task automatic reset_mid();
    i_rst_n = 0;
    repeat (3) @(negedge i_clk_sys);
    i_rst_n = 1;
    repeat (6) @(negedge i_clk_sys);
    chk(16'(o_power_state), 16'(SUVM_ST_OFF));
    chk(16'(o_system_irq), 16'h0000);
    rreg(SUVM_ADDR_IRQ_STATUS_TWO, 16'h0000);
    rreg(SUVM_ADDR_SUPPLY_CHECK_COMPARATOR, 16'h0025);
  endtask : reset_mid
  initial begin
    repeat (20) @(negedge i_clk_sys);
    i_rst_n = 1;
    @(negedge i_clk_sys);
    rreg(SUVM_ADDR_SUPPLY_CHECK_COMPARATOR, 16'h0025);
    rreg(SUVM_ADDR_IRQ_STATUS_TWO, 16'h0008);
    chk(16'(o_power_state), 16'(SUVM_ST_BACKUP));
    go(8'h21, SUVM_ST_OFF);
    go(8'h23, SUVM_ST_ACTIVE);
    line(8'h1E);
    chk(16'(o_system_irq), 16'h0001);
    chk(16'(o_power_state), 16'(SUVM_ST_ACTIVE));
    rreg(SUVM_ADDR_IRQ_STATUS_TWO, 16'h0008);
    rreg(SUVM_ADDR_IRQ_STATUS_TWO, 16'h0000);
    wreg(SUVM_ADDR_IRQ_STATUS_TWO_MASK, 16'h0008);
    wreg(SUVM_ADDR_SUPPLY_CHECK_COMPARATOR, 16'h4000);
    rreg(SUVM_ADDR_SUPPLY_CHECK_COMPARATOR, 16'h4025);
    line(8'h23);
    line(8'h1E);
    chk(16'(o_system_irq), 16'h0000);
    chk(16'(o_power_state), 16'(SUVM_ST_OFF));
    rreg(SUVM_ADDR_IRQ_STATUS_TWO, 16'h0008);
    i_key_unlocked = 1;
    // startup kept above shutdown for hysteresis
    wreg(SUVM_ADDR_SUPPLY_CHECK_COMPARATOR, 16'h0014);
    chk(16'({o_shutdown_threshold, o_startup_threshold}), 16'h000C);
    go(8'h22, SUVM_ST_ACTIVE);
    req(3'h1, SUVM_ST_HIBERNATE);
    req(3'h2, SUVM_ST_ACTIVE);
    req(3'h4, SUVM_ST_OFF);
    go(8'h22, SUVM_ST_ACTIVE);
    req(3'h1, SUVM_ST_HIBERNATE);
    line(8'h00);
    chk(16'(o_power_state), 16'(SUVM_ST_BACKUP));
    line(8'h23);
    chk(16'(o_power_state), 16'(SUVM_ST_OFF));
    reset_mid();
    final_report();
  end
  task automatic final_report();
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
endmodule : supply_undervoltage_lockout_monitor_test
`default_nettype wire
